// file: core/tdma_pkg.sv
/*
  Shared constants for the framed pattern memory block: pattern word
  layout, frame geometry, register map and sync selection codes.
  Assumes a single 250 MHz clock domain and an AHB-Lite register bus.
*/
// How it works
// - Active slot takes user bits frame after frame
// - Enabled slot words: burst one, data loaded
// - Disabled slot words: burst zero, data ignored
// - Repeat marker on final user bit, or alone in word 0 when no user bits or no slots
// - Repeat marker sits at bit seven
// - Image written once, replayed until reconfigured
// - 156-word slots, guard word every fourth
// - Two 57-bit fields plus 42 framing bits
// - One 32-bit word per payload bit
// - Sync pulses per frame, slot, or all
// - One data source per slot only
// - Memory sized in 1024-byte blocks, rounded up
// - Bit zero data, ignored when burst clear
package tdma_pkg;

  // ****************************************************************
  // Pattern word layout
  // ****************************************************************
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned DATA_BIT    = 0;
  localparam int unsigned BURST_BIT   = 2;
  localparam int unsigned REPEAT_BIT  = 7;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int unsigned SLOT_WORDS  = 156;
  localparam int unsigned GUARD_EVERY = 4;
  localparam int unsigned SLOTS       = 8;
  localparam int unsigned FIELD_BITS  = 57;
  localparam int unsigned USER_BITS   = 114;
  localparam int unsigned CTRL_BITS   = 42;
  // Positions of the two user fields inside a slot (tail 3, field, 27 mid)
  localparam int unsigned FIELD0_POS  = 3;
  localparam int unsigned FIELD1_POS  = 87;
  localparam int unsigned BLOCK_BYTES = 1024;
  localparam int unsigned BYTES_WORD  = 4;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFF    = 8'h00;
  localparam logic [7:0] SLOT_OFF    = 8'h04;
  localparam logic [7:0] LEN_OFF     = 8'h08;
  localparam logic [7:0] STAT_OFF    = 8'h0c;
  localparam logic [7:0] UDATA_OFF   = 8'h10;
  localparam logic [7:0] WADDR_OFF   = 8'h14;
  localparam logic [7:0] WDATA_OFF   = 8'h18;
  localparam logic [7:0] BLOCKS_OFF  = 8'h1c;

  // Control register fields
  localparam int unsigned CTRL_RUN   = 0;
  localparam int unsigned CTRL_BUILD = 1;
  localparam int unsigned CTRL_SYNC  = 4;

  // Sync selection codes
  localparam logic [1:0] SYNC_FRAME = 2'h0;
  localparam logic [1:0] SYNC_SLOT  = 2'h1;
  localparam logic [1:0] SYNC_ALL   = 2'h2;

endpackage : tdma_pkg

// file: core/pattern_reader.sv
/*
  Pattern word replay engine: steps through the pattern memory one word
  per bit enable and wraps after the word with the repeat marker.
  Assumes memory read data is valid one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module pattern_reader #(
  parameter int unsigned AW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          run,      // Replay allowed
  input  wire logic          bit_en,   // One bit period
  output logic      [AW-1:0] rd_addr,  // Word address to memory
  input  wire logic [31:0]   rd_word,  // Word for rd_addr
  output logic               word_vld, // Pulse: word presented
  output logic               data_bit,
  output logic               burst_on
);

  // ****************************************************************
  // Address walk
  // ****************************************************************
  logic [AW-1:0] addr_q, addr_d;
  logic          vld_q, vld_d;
  logic          dat_q, dat_d;
  logic          bst_q, bst_d;

  // Next address: wrap after marker word
  always_comb begin
    addr_d = addr_q;
    vld_d  = 1'b0;
    dat_d  = dat_q;
    bst_d  = bst_q;
    if (!run) begin
      addr_d = '0;
      bst_d  = 1'b0;
    end else if (bit_en) begin
      vld_d = 1'b1;
      dat_d = rd_word[tdma_pkg::DATA_BIT];
      // Carrier blanked when burst clear
      bst_d = rd_word[tdma_pkg::BURST_BIT];
      if (rd_word[tdma_pkg::REPEAT_BIT]) begin
        addr_d = '0;
      end else begin
        addr_d = addr_q + 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      vld_q  <= 1'b0;
      dat_q  <= 1'b0;
      bst_q  <= 1'b0;
    end else begin
      addr_q <= addr_d;
      vld_q  <= vld_d;
      dat_q  <= dat_d;
      bst_q  <= bst_d;
    end
  end

  assign rd_addr  = addr_q;
  assign word_vld = vld_q;
  // Data meaningless without burst
  assign data_bit = dat_q & bst_q;
  assign burst_on = bst_q;

endmodule : pattern_reader
`default_nettype wire

// file: core/tdma_framed_pattern_memory.sv
/*
  Framed pattern memory: builds a TDMA pattern image from user bits,
  stores it as 32-bit words, and replays it to a modulator with sync.
  Assumes an AHB-Lite master, one 250 MHz clock, and a modulator
  that samples data_bit and burst_on the cycle after each bit_en pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module tdma_framed_pattern_memory #(
  parameter int unsigned AW      = 12,  // Pattern word address width
  parameter int unsigned UW      = 10,  // User bit buffer address width
  parameter int unsigned BIT_DIV = 4    // Clocks per bit period
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             bit_en,
  output logic             data_bit,
  output logic             burst_on,
  output logic             sync_out
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0] mem [0:(1<<AW)-1]; // Pattern words, one per bit
  logic        ubits [0:(1<<UW)-1]; // User file bits

  typedef enum logic [1:0] {ST_IDLE, ST_BUILD, ST_DONE} build_e;

  // ****************************************************************
  // Bus slave registers
  // ****************************************************************
  logic          run_q, run_d;
  logic [1:0]    sync_q, sync_d;
  localparam int unsigned SLOTS_W = tdma_pkg::SLOTS;
  logic [SLOTS_W-1:0] slot_en_q, slot_en_d; // User-file slots
  logic [2:0]    sync_slot_q, sync_slot_d;
  logic [UW:0]   ulen_q, ulen_d;          // User file length in bits
  logic [UW-1:0] uwa_q, uwa_d;            // User bit write pointer
  logic [AW-1:0] dwa_q, dwa_d;            // Direct word address
  logic          ap_q, ap_d;              // Data phase pending
  logic          apw_q, apw_d;
  logic [7:0]    apa_q, apa_d;
  logic          start_build;
  logic [31:0]   rdata_d, rdata_q;

  // ****************************************************************
  // Build engine state
  // ****************************************************************
  build_e        bst_q, bst_d;
  logic [AW-1:0] bw_q, bw_d;              // Word being written
  logic [2:0]    bslot_q, bslot_d;
  logic [7:0]    bpos_q, bpos_d;          // Word within slot
  logic [1:0]    bquad_q, bquad_d;        // Slot count modulo four
  logic [UW:0]   bu_q, bu_d;              // Next user bit
  logic [AW:0]   total_q, total_d;        // Words in image

  // Slot length with guard word on every fourth slot
  function automatic logic [7:0] slot_len(input logic [1:0] quad);
    slot_len = (quad == 2'(tdma_pkg::GUARD_EVERY - 1)) ?
               8'(tdma_pkg::SLOT_WORDS + 1) : 8'(tdma_pkg::SLOT_WORDS);
  endfunction : slot_len

  // User field membership: two 57-bit fields
  function automatic logic in_field(input logic [7:0] pos);
    in_field = ((pos >= 8'(tdma_pkg::FIELD0_POS)) &&
                (pos < 8'(tdma_pkg::FIELD0_POS + tdma_pkg::FIELD_BITS))) ||
               ((pos >= 8'(tdma_pkg::FIELD1_POS)) &&
                (pos < 8'(tdma_pkg::FIELD1_POS + tdma_pkg::FIELD_BITS)));
  endfunction : in_field

  logic          bus_go;
  assign bus_go = hsel & hready & htrans[1];

  // Register next state and bus decode
  always_comb begin
    run_d       = run_q;
    sync_d      = sync_q;
    slot_en_d   = slot_en_q;
    sync_slot_d = sync_slot_q;
    ulen_d      = ulen_q;
    uwa_d       = uwa_q;
    dwa_d       = dwa_q;
    ap_d        = bus_go;
    apw_d       = hwrite;
    apa_d       = haddr[7:0];
    start_build = 1'b0;
    rdata_d     = rdata_q;
    // Read data prepared in address phase
    if (bus_go && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        // Same layout as the write: run b0, sync b5:4, sync slot b10:8
        tdma_pkg::CTRL_OFF:   rdata_d = {21'h0, sync_slot_q, 2'h0, sync_q, 3'h0, run_q};
        tdma_pkg::SLOT_OFF:   rdata_d = 32'(slot_en_q);
        tdma_pkg::LEN_OFF:    rdata_d = 32'(ulen_q);
        tdma_pkg::STAT_OFF:   rdata_d = {29'h0, (bst_q == ST_DONE), (bst_q == ST_BUILD),
                                         burst_on};
        tdma_pkg::WADDR_OFF:  rdata_d = 32'(dwa_q);
        tdma_pkg::WDATA_OFF:  rdata_d = mem[dwa_q];
        // Image size in 1024-byte blocks, rounded up
        tdma_pkg::BLOCKS_OFF: rdata_d = 32'((32'(total_q) * tdma_pkg::BYTES_WORD +
                                        tdma_pkg::BLOCK_BYTES - 1) / tdma_pkg::BLOCK_BYTES);
        default:              rdata_d = 32'h0;
      endcase
    end
    // Writes land in data phase
    if (ap_q && apw_q) begin
      case ({apa_q[7:2], 2'b00})
        tdma_pkg::CTRL_OFF: begin
          run_d       = hwdata[tdma_pkg::CTRL_RUN];
          sync_d      = hwdata[tdma_pkg::CTRL_SYNC +: 2];
          sync_slot_d = hwdata[tdma_pkg::CTRL_SYNC + 4 +: 3];
          // Rebuild only on request after reconfiguration
          start_build = hwdata[tdma_pkg::CTRL_BUILD];
          if (start_build) begin
            run_d = 1'b0;
          end
        end
        // One bit per slot: set means user file, clear means off
        tdma_pkg::SLOT_OFF:  slot_en_d = hwdata[SLOTS_W-1:0];
        tdma_pkg::LEN_OFF: begin
          ulen_d = hwdata[UW:0];
          uwa_d  = '0;
        end
        tdma_pkg::UDATA_OFF: uwa_d = uwa_q + 1'b1;
        tdma_pkg::WADDR_OFF: dwa_d = hwdata[AW-1:0];
        default: ;
      endcase
    end
  end

  // Build walk over frames
  logic          bwe;
  logic [31:0]   bword;
  logic          last_user;
  logic          act;
  always_comb begin
    bst_d   = bst_q;
    bw_d    = bw_q;
    bslot_d = bslot_q;
    bpos_d  = bpos_q;
    bquad_d = bquad_q;
    bu_d    = bu_q;
    total_d = total_q;
    bwe     = 1'b0;
    bword   = 32'h0;
    act     = slot_en_q[bslot_q];
    last_user = 1'b0;
    case (bst_q)
      ST_IDLE, ST_DONE: begin
        if (start_build) begin
          bst_d   = ST_BUILD;
          bw_d    = '0;
          bslot_d = '0;
          bpos_d  = '0;
          bquad_d = '0;
          bu_d    = '0;
        end
      end
      ST_BUILD: begin
        bwe = 1'b1;
        if (act) begin
          bword[tdma_pkg::BURST_BIT] = 1'b1;
          if (in_field(bpos_q)) begin
            // User bits fill the active slot's fields
            bword[tdma_pkg::DATA_BIT] = ubits[bu_q[UW-1:0]];
            bu_d = bu_q + 1'b1;
            last_user = (bu_q + 1'b1 == ulen_q);
          end else begin
            bword[tdma_pkg::DATA_BIT] = 1'b0; // Framing content
          end
        end else begin
          bword[tdma_pkg::BURST_BIT] = 1'b0;
        end
        bword[tdma_pkg::REPEAT_BIT] = last_user;
        bw_d   = bw_q + 1'b1;
        bpos_d = bpos_q + 1'b1;
        if (bpos_q == slot_len(bquad_q) - 8'd1) begin
          bpos_d  = '0;
          bquad_d = bquad_q + 1'b1;
          bslot_d = bslot_q + 1'b1;
        end
        // Finish after marker, or on empty/full memory
        if (last_user || (ulen_q == '0) || (slot_en_q == '0) || (&bw_q)) begin
          bst_d   = ST_DONE;
          total_d = {1'b0, bw_q} + 1'b1;
        end
      end
      default: bst_d = ST_IDLE;
    endcase
  end

  // Memory writes: built image and user bits
  always_ff @(posedge clk) begin
    if (bwe) begin
      mem[bw_q] <= (ulen_q == '0 || slot_en_q == '0) ?
                   (32'h1 << tdma_pkg::REPEAT_BIT) : bword;
    end
    if (ap_q && apw_q && ({apa_q[7:2], 2'b00} == tdma_pkg::UDATA_OFF)) begin
      ubits[uwa_q] <= hwdata[0];
    end
  end

  // Register flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0; sync_q <= tdma_pkg::SYNC_FRAME; slot_en_q <= '0;
      sync_slot_q <= '0; ulen_q <= '0; uwa_q <= '0; dwa_q <= '0;
      ap_q <= 1'b0; apw_q <= 1'b0; apa_q <= '0; rdata_q <= '0;
      bst_q <= ST_IDLE; bw_q <= '0; bslot_q <= '0; bpos_q <= '0;
      bquad_q <= '0; bu_q <= '0; total_q <= '0;
    end else begin
      run_q <= run_d; sync_q <= sync_d; slot_en_q <= slot_en_d;
      sync_slot_q <= sync_slot_d; ulen_q <= ulen_d; uwa_q <= uwa_d;
      dwa_q <= dwa_d; ap_q <= ap_d; apw_q <= apw_d; apa_q <= apa_d;
      rdata_q <= rdata_d; bst_q <= bst_d; bw_q <= bw_d;
      bslot_q <= bslot_d; bpos_q <= bpos_d; bquad_q <= bquad_d;
      bu_q <= bu_d; total_q <= total_d;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // Replay and sync
  // ****************************************************************
  logic [7:0]    div_q, div_d;
  logic [AW-1:0] rd_addr;
  logic [31:0]   rd_word_q;
  logic          replay;
  logic [7:0]    rpos_q, rpos_d;
  logic [1:0]    rquad_q, rquad_d;
  logic [2:0]    rslot_q, rslot_d;
  logic          spulse_d, spulse_q;      // Sync pulse, next and registered

  assign replay = run_q & (bst_q == ST_DONE);

  // Bit period divider and slot tracking for sync
  always_comb begin
    div_d   = (div_q == 8'(BIT_DIV - 1) || !replay) ? 8'h0 : div_q + 8'h1;
    rpos_d  = rpos_q;
    rquad_d = rquad_q;
    rslot_d = rslot_q;
    spulse_d = 1'b0;
    if (!replay) begin
      rpos_d = '0; rquad_d = '0; rslot_d = '0;
    end else if (bit_en) begin
      // Sync pulse at slot start per selection
      if (rpos_q == 8'h0) begin
        case (sync_q)
          tdma_pkg::SYNC_FRAME: spulse_d = (rslot_q == 3'h0);
          tdma_pkg::SYNC_SLOT:  spulse_d = (rslot_q == sync_slot_q);
          tdma_pkg::SYNC_ALL:   spulse_d = 1'b1;
          default:              spulse_d = 1'b0;
        endcase
      end
      rpos_d = rpos_q + 8'h1;
      if (rd_word_q[tdma_pkg::REPEAT_BIT]) begin
        rpos_d = '0; rquad_d = '0; rslot_d = '0;
      end else if (rpos_q == slot_len(rquad_q) - 8'd1) begin
        rpos_d  = '0;
        rquad_d = rquad_q + 2'h1;
        rslot_d = rslot_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0; rpos_q <= '0; rquad_q <= '0; rslot_q <= '0; spulse_q <= 1'b0;
    end else begin
      div_q <= div_d; rpos_q <= rpos_d; rquad_q <= rquad_d;
      rslot_q <= rslot_d; spulse_q <= spulse_d;
    end
  end

  // Memory read port, registered
  always_ff @(posedge clk) begin
    rd_word_q <= mem[rd_addr];
  end

  assign bit_en   = replay && (div_q == 8'(BIT_DIV - 1));
  assign sync_out = spulse_q;

  pattern_reader #(.AW(AW)) u_reader (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (replay),
    .bit_en   (bit_en),
    .rd_addr  (rd_addr),
    .rd_word  (rd_word_q),
    .word_vld (),
    .data_bit (data_bit),
    .burst_on (burst_on)
  );

endmodule : tdma_framed_pattern_memory
`default_nettype wire

// file: verification/pattern_chk.sv
/*
  Checker for the framed pattern memory: bus answer, replay pacing,
  blanking and sync pulse shape, seen only at the top module's ports.
  Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`default_nettype none
module pattern_chk #(
  parameter int unsigned BIT_DIV = 4  // Clocks per bit period
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        bit_en,
  input wire logic        data_bit,
  input wire logic        burst_on,
  input wire logic        sync_out
);
  // ****************************************************************
  // Helper: distance between bit periods
  // ****************************************************************
  logic [7:0] gap_q, gap_d;   // Clocks since last bit_en
  logic       seen_q, seen_d; // First bit_en has gone by
  // Saturates so a stalled replay cannot wrap into a false match
  always_comb begin
    gap_d  = bit_en ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
    seen_d = seen_q | bit_en;
  end
  // Register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= 8'h00;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ready; hreadyout == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response given");
  property p_blank; !burst_on |-> !data_bit; endproperty
  a_blank: assert property (p_blank) else $error("data while blanked");
  property p_rate; bit_en && seen_q |-> gap_q == 8'(BIT_DIV - 1); endproperty
  a_rate: assert property (p_rate) else $error("bit period length wrong");
  property p_hold; !$past(bit_en) |-> $stable(burst_on) && $stable(data_bit); endproperty
  a_hold: assert property (p_hold) else $error("word changed off period");
  property p_pulse; sync_out |=> !sync_out; endproperty
  a_pulse: assert property (p_pulse) else $error("sync longer than one");
  property p_sync_word; sync_out |-> $past(bit_en); endproperty
  a_sync_word: assert property (p_sync_word) else $error("sync off word");
  property p_unmapped;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] >= 8'h20 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : pattern_chk
bind tdma_framed_pattern_memory pattern_chk #(.BIT_DIV(BIT_DIV)) i_chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bit_en(bit_en),
  .data_bit(data_bit), .burst_on(burst_on), .sync_out(sync_out));
`default_nettype wire

// file: verification/baseband_sink.sv
/*
  Modulator model: takes one word per bit period, the cycle after
  bit_en, and records sync, burst and data for the bench to inspect.
  Assumes it shares clock and reset with the design.
*/
`timescale 1ns/1ps
`default_nettype none
module baseband_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_en,
  input wire logic data_bit,
  input wire logic burst_on,
  input wire logic sync_out
);
  logic [2:0] cap [0:3199]; // {sync, burst, data} per word
  int         n_words;      // Words taken since reset
  logic       take;         // Word stands this cycle
  // Capture; a full store stops quietly, the bench counts shortfalls
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take    <= 1'b0;
      n_words <= 0;
    end else begin
      take <= bit_en;
      if (take && n_words < 3200) begin
        // Carrier keyed only while burst_on, data read as is
        cap[n_words] <= {sync_out, burst_on, data_bit};
        n_words      <= n_words + 1;
      end
    end
  end
endmodule : baseband_sink
`default_nettype wire

// file: verification/tdma_framed_pattern_memory_bench.sv
/*
  Bench: loads 228 user bits into slot one, builds, checks image words
  over the bus and the replayed stream in each sync mode.
  Assumes zero wait AHB-Lite answers and the modulator model.
*/
`timescale 1ns/1ps
`default_nettype none
module tdma_framed_pattern_memory_bench;
  localparam int SW  = tdma_pkg::SLOT_WORDS;
  localparam int GE  = tdma_pkg::GUARD_EVERY;
  localparam int FB  = tdma_pkg::FIELD_BITS;
  localparam int F0  = tdma_pkg::FIELD0_POS;
  localparam int F1  = tdma_pkg::FIELD1_POS;
  localparam int FRM = SW * tdma_pkg::SLOTS + tdma_pkg::SLOTS / GE; // Frame words
  localparam int IMG = FRM + SW + F1 + FB; // Image ends at last user bit
  logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, x;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        bit_en, data_bit, burst_on, sync_out;
  int          fails, n_checks;
  int          offs [8] = '{0, 155, 159, 215, 1250, 1409, 1548, 1549};
  assign hready = hreadyout; // Single slave drives the bus ready
  tdma_framed_pattern_memory #(.AW(12), .UW(10), .BIT_DIV(4)) i_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bit_en(bit_en),
    .data_bit(data_bit), .burst_on(burst_on), .sync_out(sync_out));
  baseband_sink i_sink (.clk(clk), .rst_n(rst_n), .bit_en(bit_en),
    .data_bit(data_bit), .burst_on(burst_on), .sync_out(sync_out));
  always #2 clk = ~clk;
  // ****************************************************************
  // Tasks and expectations
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel   <= 1'b1;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    x = hrdata;
  endtask : bus
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(n, x, e);
  endtask : rchk
  // Arbitrary but irregular user file content
  function automatic logic ubit(input int k);
    return logic'(k[0] ^ k[2] ^ k[5]);
  endfunction : ubit
  // Slot and position of an image offset; every fourth slot has a guard word
  function automatic void locate(input int o, output int sl, output int ps);
    int len;
    ps = o % FRM;
    sl = 0;
    len = SW;
    while (ps >= len) begin
      ps = ps - len;
      sl = sl + 1;
      len = SW + ((sl % GE) == GE - 1);
    end
  endfunction : locate
  // Marker, burst and data bits of an image word
  function automatic logic [31:0] exp_word(input int o);
    int   sl, ps, k;
    logic inf;
    locate(o, sl, ps);
    inf = (ps >= F0 && ps < F0 + FB) || (ps >= F1 && ps < F1 + FB);
    k = (o / FRM) * tdma_pkg::USER_BITS + ((ps >= F1) ? ps - F1 + FB : ps - F0);
    if (sl != 1) return 32'h0;
    return {24'h0, o == IMG - 1, 4'h0, 1'b1, 1'b0, inf & ubit(k)};
  endfunction : exp_word
  function automatic logic [31:0] exp_sync(input int o, input logic [1:0] m);
    int sl, ps;
    locate(o, sl, ps);
    if (ps != 0) return 32'h0;
    if (m == tdma_pkg::SYNC_FRAME) return {31'h0, sl == 0};
    if (m == tdma_pkg::SYNC_SLOT) return {31'h0, sl == 1};
    return 32'h1;
  endfunction : exp_sync
  // Reset, load the file, build and wait for done under a bound
  task automatic load();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b1, tdma_pkg::LEN_OFF, 32'he4);
    for (int k = 0; k < 228; k++) bus(1'b1, tdma_pkg::UDATA_OFF, {31'h0, ubit(k)});
    bus(1'b1, tdma_pkg::SLOT_OFF, 32'h2);
    bus(1'b1, tdma_pkg::CTRL_OFF, 32'h2);
    for (int t = 0; t < 2000 && x[2] !== 1'b1; t++) bus(1'b0, tdma_pkg::STAT_OFF, 32'h0);
    check("build done", {31'h0, x[2]}, 32'h1);
  endtask : load
  // Run without rebuilding, then compare the captured stream
  task automatic replay(input logic [1:0] m, input int n);
    logic [31:0] e;
    bus(1'b1, tdma_pkg::CTRL_OFF, 32'h101 | {26'h0, m, 4'h0});
    rchk("ctrl readback", tdma_pkg::CTRL_OFF, 32'h101 | {26'h0, m, 4'h0});
    for (int t = 0; t < 8 * n && i_sink.n_words < n; t++) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      e = exp_word(i % IMG);
      check("burst_on", {31'h0, i_sink.cap[i][1]}, {31'h0, e[2]});
      check("data_bit", {31'h0, i_sink.cap[i][0]}, {31'h0, e[0]});
      check("sync_out", {31'h0, i_sink.cap[i][2]}, exp_sync(i % IMG, m));
    end
    $display("test replay mode %0d done", m);
  endtask : replay
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    {clk, rst_n, hsel, hwrite, htrans, haddr, hwdata, x} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk("ctrl reset", tdma_pkg::CTRL_OFF, 32'h0);
    rchk("stat reset", tdma_pkg::STAT_OFF, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff);
    rchk("unmapped", 8'h20, 32'h0);
    $display("test registers done");
    load();
    foreach (offs[i]) begin
      bus(1'b1, tdma_pkg::WADDR_OFF, offs[i]);
      bus(1'b0, tdma_pkg::WDATA_OFF, 32'h0);
      check("pattern word", x & 32'h85, exp_word(offs[i]));
    end
    rchk("blocks", tdma_pkg::BLOCKS_OFF, (IMG * 4 + 1023) / 1024);
    $display("test image done");
    replay(tdma_pkg::SYNC_FRAME, 2 * IMG);
    load();
    replay(tdma_pkg::SYNC_SLOT, 1600);
    load();
    replay(tdma_pkg::SYNC_ALL, 1600);
    final_report();
  end
  initial begin
    // About 32k clocks of tests expected; 50k clocks leaves ample margin
    #200000;
    fails++;
    final_report();
  end
endmodule : tdma_framed_pattern_memory_bench
`default_nettype wire
